// >>> siep_pkg.sv
// constants, carriers and states shared by the interrupt event pulser
package siep_pkg;

  localparam int SIEP_CLK_MHZ    = 25;
  localparam int SIEP_FRAME_BITS = 16;
  localparam int SIEP_NUM_SRC    = 32;
  localparam int SIEP_NUM_IO     = 6;
  localparam int SIEP_NUM_MON    = 6;
  localparam int SIEP_NUM_TWARN  = 3;
  localparam int SIEP_CNT_W      = 12;

  // clocks expected between chip select edges
  localparam logic [4:0] SIEP_FRAME_CLKS = 5'h10;

  // source positions in the event vector
  localparam int SIEP_SRC_IO_CHG   = 0;
  localparam int SIEP_SRC_IO_WAKE  = 6;
  localparam int SIEP_SRC_BUS_WAKE = 12;
  localparam int SIEP_SRC_TXD_DOM  = 13;
  localparam int SIEP_SRC_RXD_REC  = 14;
  localparam int SIEP_SRC_BUS_DOM  = 15;
  localparam int SIEP_SRC_SNS_TO   = 16;
  localparam int SIEP_SRC_AUX_TO   = 17;
  localparam int SIEP_SRC_TWARN    = 18;
  localparam int SIEP_SRC_MON      = 21;
  localparam int SIEP_SRC_REQ      = 27;
  localparam int SIEP_SRC_SPI_SEC  = 28;
  localparam int SIEP_SRC_SPI_CLK  = 29;
  localparam int SIEP_SRC_SPI_REQ  = 30;
  localparam int SIEP_SRC_SPI_PAR  = 31;

  // register addresses in the 5-bit frame address field
  localparam logic [4:0] SIEP_ADDR_CFG   = 5'h01;
  localparam logic [4:0] SIEP_ADDR_REQ   = 5'h02;
  localparam logic [4:0] SIEP_ADDR_TOPO  = 5'h03;
  localparam logic [4:0] SIEP_ADDR_MASK0 = 5'h04;
  localparam logic [4:0] SIEP_ADDR_FLAG0 = 5'h08;
  localparam logic [4:0] SIEP_ADDR_LIMIT = 5'h0c;

  // reset values
  localparam logic [4:0] SIEP_CFG_RST  = 5'h04;
  localparam logic [7:0] SIEP_MASK_RST = 8'h00;

  // pulse lengths per code, and the high gap between two pulses
  localparam int SIEP_PULSE0_US = 20;
  localparam int SIEP_PULSE1_US = 40;
  localparam int SIEP_PULSE2_US = 80;
  localparam int SIEP_PULSE3_US = 160;
  localparam int SIEP_GAP_US    = 2;
  localparam logic [11:0] SIEP_PULSE0_CYC = 12'(SIEP_PULSE0_US * SIEP_CLK_MHZ);
  localparam logic [11:0] SIEP_PULSE1_CYC = 12'(SIEP_PULSE1_US * SIEP_CLK_MHZ);
  localparam logic [11:0] SIEP_PULSE2_CYC = 12'(SIEP_PULSE2_US * SIEP_CLK_MHZ);
  localparam logic [11:0] SIEP_PULSE3_CYC = 12'(SIEP_PULSE3_US * SIEP_CLK_MHZ);
  localparam logic [11:0] SIEP_GAP_CYC    = 12'(SIEP_GAP_US * SIEP_CLK_MHZ);

  typedef struct packed {
    logic       write;
    logic [4:0] addr;
    logic [7:0] data;
    logic       sec;
    logic       par;
  } siep_frame_t;

  typedef struct packed {
    logic       sns_ext;
    logic       aux_ext;
    logic       out_en;
    logic [1:0] len;
  } siep_cfg_t;

  typedef enum logic [2:0] {
    SIEP_IDLE  = 3'b001,
    SIEP_PULSE = 3'b010,
    SIEP_GAP   = 3'b100
  } siep_state_t;

endpackage : siep_pkg

// >>> siep_sync.sv
// two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module siep_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else if (clk_en) begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule : siep_sync

// >>> siep_spi_check.sv
// spi frame capture with clock count and parity checks
`timescale 1ns/1ps
module siep_spi_check
  import siep_pkg::*;
(
  input  wire logic  clock,
  input  wire logic  rst,
  input  wire logic  clk_en,
  input  wire logic  sclk,
  input  wire logic  chip_select_n,
  input  wire logic  mosi,
  output logic       frame_done,
  output siep_frame_t frame,
  output logic       clk_ok,
  output logic       par_ok
);

  logic        sclk_d;
  logic        cs_d;
  logic [4:0]  cnt;
  logic [15:0] shift;
  logic        sclk_rise;
  logic        cs_fall;
  logic        cs_rise;

  assign sclk_rise = sclk & ~sclk_d;
  assign cs_fall   = ~chip_select_n & cs_d;
  assign cs_rise   = chip_select_n & ~cs_d;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_d <= 1'b0;
      cs_d   <= 1'b1;
    end else if (clk_en) begin
      sclk_d <= sclk;
      cs_d   <= chip_select_n;
    end
  end

  // counter saturates so that very long frames still read as wrong
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt   <= 5'h00;
      shift <= 16'h0000;
    end else if (clk_en) begin
      if (cs_fall) begin
        cnt   <= 5'h00;
        shift <= 16'h0000;
      end else if (~chip_select_n && sclk_rise) begin
        shift <= {shift[14:0], mosi};
        if (cnt != 5'h1f) begin
          cnt <= cnt + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      frame_done <= 1'b0;
      frame      <= '0;
      clk_ok     <= 1'b0;
      par_ok     <= 1'b0;
    end else if (clk_en) begin
      frame_done <= cs_rise;
      if (cs_rise) begin
        frame  <= shift;
        clk_ok <= (cnt == SIEP_FRAME_CLKS);
        par_ok <= ^shift;
      end
    end
  end

endmodule : siep_spi_check

// >>> siep_event_pulser.sv
// interrupt event latching, masking and low pulse generation
// Overview of operation
// - any enabled event drives a low pulse on the interrupt pin, then high
// - pin behaviour and pulse length written during init, used for later pulses
// - masked sources never cause a pulse
// - in main state, frame with clock count other than 16 flags error
// - malformed access, init-only write in normal mode, unknown address flag error
// - in main state, frame parity failure flags error
// - secured check failure on an spi transfer flags error
// - host request command produces a pulse like any event
// - each of six io pins raises an event on level change
// - each of six io pins raises its own wake event
// - can bus wake activity raises an event
// - transmit data clamped dominant raises an event
// - receive data clamped recessive raises an event
// - can bus stuck dominant raises an event
// - limit duration expiry raises event only with external pass transistor
// - pass transistor thermal warning raises an event
// - pre-converter step-down or step-up state reported to host
`timescale 1ns/1ps
module siep_event_pulser
  import siep_pkg::*;
#(
  parameter int NUM_IO  = SIEP_NUM_IO,
  parameter int NUM_MON = SIEP_NUM_MON
) (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic                    clk_en,
  input  wire logic                    init_phase,
  input  wire logic                    main_state,
  input  wire logic                    sclk,
  input  wire logic                    chip_select_n,
  input  wire logic                    mosi,
  input  wire logic [NUM_IO-1:0]       io_level,
  input  wire logic [NUM_IO-1:0]       io_wake_event,
  input  wire logic                    bus_wake_event,
  input  wire logic                    txd_clamp_dom,
  input  wire logic                    rxd_clamp_rec,
  input  wire logic                    bus_stuck_dom,
  input  wire logic                    sns_limit_timeout,
  input  wire logic                    aux_limit_timeout,
  input  wire logic [2:0]              pass_twarn,
  input  wire logic [NUM_MON-1:0]      monitor_fault,
  input  wire logic                    pre_converter_topology_in,
  output logic                         irq_pulse_out_n,
  output logic                         pre_converter_topology_state,
  output logic [SIEP_NUM_SRC-1:0]      event_flags,
  output logic [7:0]                   read_data,
  output logic                         read_valid
);

  localparam int LVL_W = NUM_IO + NUM_MON + 9;

  logic [LVL_W-1:0]        lvl_raw;
  logic [LVL_W-1:0]        lvl;
  logic [2:0]              spi_s;
  logic [NUM_IO-1:0]       io_s;
  logic [NUM_IO-1:0]       io_prev;
  logic [LVL_W-NUM_IO-2:0] ana_s;
  logic [LVL_W-NUM_IO-2:0] ana_prev;
  logic [LVL_W-NUM_IO-2:0] ana_rise;
  logic [2:0]              warm;
  logic                    primed;
  logic                    frame_done;
  siep_frame_t             frame;
  logic                    clk_ok;
  logic                    par_ok;
  siep_cfg_t               cfg;
  logic [7:0]              mask [4];
  logic [SIEP_NUM_SRC-1:0] mask_all;
  logic [SIEP_NUM_SRC-1:0] evt;
  logic [SIEP_NUM_SRC-1:0] clr;
  logic                    sec_ok;
  logic                    good;
  logic                    known;
  logic                    malformed;
  logic                    init_viol;
  logic                    act;
  logic                    req_cmd;
  logic                    fire;
  logic                    pend;
  siep_state_t             state;
  siep_state_t             next_state;
  logic [SIEP_CNT_W-1:0]   cnt;
  logic [SIEP_CNT_W-1:0]   len_cyc;

  // io levels and analog status are synchronised in one bank; the spi pins in a second, wake events not at all
  assign lvl_raw = {pre_converter_topology_in, monitor_fault, pass_twarn,
                    aux_limit_timeout, sns_limit_timeout, bus_stuck_dom,
                    rxd_clamp_rec, txd_clamp_dom, io_level};

  siep_sync #(
    .WIDTH   (LVL_W),
    .RST_VAL ('0)
  ) u_lvl_sync (
    .clock  (clock),
    .rst    (rst),
    .clk_en (clk_en),
    .din    (lvl_raw),
    .dout   (lvl)
  );

  siep_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h2)
  ) u_spi_sync (
    .clock  (clock),
    .rst    (rst),
    .clk_en (clk_en),
    .din    ({sclk, chip_select_n, mosi}),
    .dout   (spi_s)
  );

  siep_spi_check u_spi_check (
    .clock         (clock),
    .rst           (rst),
    .clk_en        (clk_en),
    .sclk          (spi_s[2]),
    .chip_select_n (spi_s[1]),
    .mosi          (spi_s[0]),
    .frame_done    (frame_done),
    .frame         (frame),
    .clk_ok        (clk_ok),
    .par_ok        (par_ok)
  );

  assign io_s  = lvl[NUM_IO-1:0];
  assign ana_s = lvl[LVL_W-2:NUM_IO];

  // history primes over the sync delay, so reset never looks like a change
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      warm     <= 3'h0;
      io_prev  <= '0;
      ana_prev <= '0;
    end else if (clk_en) begin
      warm     <= {warm[1:0], 1'b1};
      io_prev  <= io_s;
      ana_prev <= ana_s;
    end
  end

  assign primed   = warm[2];
  assign ana_rise = ana_s & ~ana_prev & {(LVL_W-NUM_IO-1){primed}};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_converter_topology_state <= 1'b0;
    end else if (clk_en) begin
      pre_converter_topology_state <= lvl[LVL_W-1];
    end
  end

  // frame decode
  assign sec_ok    = (frame.sec == ~^{frame.write, frame.addr,
                                       frame.data[7:6]});
  assign good      = clk_ok & sec_ok & (par_ok | ~main_state);
  assign known     = (frame.addr >= SIEP_ADDR_CFG) &&
                     (frame.addr < SIEP_ADDR_LIMIT);
  assign malformed = (~frame.write & (frame.data != 8'h00)) |
                     (frame.write & ((frame.addr == SIEP_ADDR_TOPO) |
                      (frame.addr >= SIEP_ADDR_FLAG0)));
  assign init_viol = frame.write & (frame.addr == SIEP_ADDR_CFG) &
                     ~init_phase;
  assign act       = frame_done & good & known & ~malformed & ~init_viol;
  assign req_cmd   = act & frame.write & (frame.addr == SIEP_ADDR_REQ) &
                     frame.data[0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg <= SIEP_CFG_RST;
    end else if (clk_en) begin
      if (act && frame.write && frame.addr == SIEP_ADDR_CFG) begin
        cfg <= frame.data[4:0];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        mask[i] <= SIEP_MASK_RST;
      end
    end else if (clk_en) begin
      if (act && frame.write && frame.addr[4:2] == SIEP_ADDR_MASK0[4:2]) begin
        mask[frame.addr[1:0]] <= frame.data;
      end
    end
  end

  assign mask_all = {mask[3], mask[2], mask[1], mask[0]};

  // read answer is registered on read_data, with read_valid high for one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      read_data  <= 8'h00;
      read_valid <= 1'b0;
    end else if (clk_en) begin
      read_valid <= act & ~frame.write;
      if (act && !frame.write) begin
        if (frame.addr == SIEP_ADDR_CFG) begin
          read_data <= {3'h0, cfg};
        end else if (frame.addr == SIEP_ADDR_TOPO) begin
          read_data <= {7'h00, pre_converter_topology_state};
        end else if (frame.addr[4:2] == SIEP_ADDR_MASK0[4:2]) begin
          read_data <= mask[frame.addr[1:0]];
        end else if (frame.addr[4:2] == SIEP_ADDR_FLAG0[4:2]) begin
          read_data <= event_flags[8*frame.addr[1:0] +: 8];
        end else begin
          read_data <= 8'h00;
        end
      end
    end
  end

  // event vector
  always_comb begin
    evt = '0;
    evt[SIEP_SRC_IO_CHG +: NUM_IO]  = (io_s ^ io_prev) & {NUM_IO{primed}};
    evt[SIEP_SRC_IO_WAKE +: NUM_IO] = io_wake_event;
    evt[SIEP_SRC_BUS_WAKE] = bus_wake_event;
    evt[SIEP_SRC_TXD_DOM]  = ana_rise[0];
    evt[SIEP_SRC_RXD_REC]  = ana_rise[1];
    evt[SIEP_SRC_BUS_DOM]  = ana_rise[2];
    evt[SIEP_SRC_SNS_TO]   = ana_rise[3] & cfg.sns_ext;
    evt[SIEP_SRC_AUX_TO]   = ana_rise[4] & cfg.aux_ext;
    evt[SIEP_SRC_TWARN +: SIEP_NUM_TWARN] = ana_rise[7:5];
    evt[SIEP_SRC_MON +: NUM_MON] = ana_rise[8 +: NUM_MON];
    evt[SIEP_SRC_REQ]     = req_cmd;
    evt[SIEP_SRC_SPI_SEC] = frame_done & clk_ok & ~sec_ok;
    evt[SIEP_SRC_SPI_CLK] = frame_done & main_state & ~clk_ok;
    evt[SIEP_SRC_SPI_REQ] = frame_done & good &
                            (~known | malformed | init_viol);
    evt[SIEP_SRC_SPI_PAR] = frame_done & clk_ok & main_state &
                            ~par_ok;
  end

  // a read clears its byte; a new event in the same cycle still sets it
  always_comb begin
    clr = '0;
    if (act && !frame.write && frame.addr[4:2] == SIEP_ADDR_FLAG0[4:2]) begin
      clr[8*frame.addr[1:0] +: 8] = 8'hff;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      event_flags <= '0;
    end else if (clk_en) begin
      event_flags <= (event_flags & ~clr) | evt;
    end
  end

  assign fire = cfg.out_en & (|(evt & ~mask_all));

  always_comb begin
    case (cfg.len)
      2'h0:    len_cyc = SIEP_PULSE0_CYC;
      2'h1:    len_cyc = SIEP_PULSE1_CYC;
      2'h2:    len_cyc = SIEP_PULSE2_CYC;
      default: len_cyc = SIEP_PULSE3_CYC;
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      SIEP_IDLE: begin
        if (fire) begin
          next_state = SIEP_PULSE;
        end
      end
      SIEP_PULSE: begin
        if (cnt == '0) begin
          next_state = SIEP_GAP;
        end
      end
      SIEP_GAP: begin
        if (cnt == '0) begin
          next_state = (pend | fire) ? SIEP_PULSE : SIEP_IDLE;
        end
      end
      default: next_state = SIEP_IDLE;
    endcase
  end

  // the gap keeps back-to-back pulses visible as separate edges
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= SIEP_IDLE;
      cnt   <= '0;
    end else if (clk_en) begin
      state <= next_state;
      if (next_state == SIEP_PULSE && state != SIEP_PULSE) begin
        cnt <= len_cyc - 12'h001;
      end else if (next_state == SIEP_GAP && state == SIEP_PULSE) begin
        cnt <= SIEP_GAP_CYC - 12'h001;
      end else if (cnt != '0) begin
        cnt <= cnt - 12'h001;
      end
    end
  end

  // events inside a pulse are merged; only the gap remembers one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend <= 1'b0;
    end else if (clk_en) begin
      if (next_state == SIEP_PULSE) begin
        pend <= 1'b0;
      end else if (state == SIEP_GAP && fire) begin
        pend <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_pulse_out_n <= 1'b1;
    end else if (clk_en) begin
      irq_pulse_out_n <= (next_state != SIEP_PULSE);
    end
  end

endmodule : siep_event_pulser

// >>> siep_event_pulser_monitor.sv
// port checker for the interrupt event pulser
`timescale 1ns/1ps
module siep_event_pulser_monitor
  import siep_pkg::*;
#(
  parameter int NUM_IO  = SIEP_NUM_IO,
  parameter int NUM_MON = SIEP_NUM_MON
) (
  input wire logic                    clock,
  input wire logic                    rst,
  input wire logic                    clk_en,
  input wire logic                    init_phase,
  input wire logic                    main_state,
  input wire logic                    sclk,
  input wire logic                    chip_select_n,
  input wire logic                    mosi,
  input wire logic [NUM_IO-1:0]       io_level,
  input wire logic [NUM_IO-1:0]       io_wake_event,
  input wire logic                    bus_wake_event,
  input wire logic                    txd_clamp_dom,
  input wire logic                    rxd_clamp_rec,
  input wire logic                    bus_stuck_dom,
  input wire logic                    sns_limit_timeout,
  input wire logic                    aux_limit_timeout,
  input wire logic [2:0]              pass_twarn,
  input wire logic [NUM_MON-1:0]      monitor_fault,
  input wire logic                    pre_converter_topology_in,
  input wire logic                    irq_pulse_out_n,
  input wire logic                    pre_converter_topology_state,
  input wire logic [SIEP_NUM_SRC-1:0] event_flags,
  input wire logic [7:0]              read_data,
  input wire logic                    read_valid
);
  logic [12:0] lo_cnt;
  logic [6:0]  hi_cnt;
  logic [2:0]  tcnt;
  logic        tprev;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // gap counter starts saturated so the first pulse needs no gap
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lo_cnt <= 13'h0000;
      hi_cnt <= 7'h7f;
    end else if (clk_en) begin
      lo_cnt <= irq_pulse_out_n ? 13'h0000 : lo_cnt + 13'h0001;
      hi_cnt <= !irq_pulse_out_n ? 7'h00 : hi_cnt + {6'h00, hi_cnt != 7'h7f};
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tcnt  <= 3'h0;
      tprev <= 1'b0;
    end else if (clk_en) begin
      tprev <= pre_converter_topology_in;
      tcnt  <= (pre_converter_topology_in != tprev) ? 3'h0 :
               tcnt + {2'h0, tcnt != 3'h7};
    end
  end
  AST_PULSE_LEN: assert property (
    $rose(irq_pulse_out_n) |->
      lo_cnt inside {13'h01f4, 13'h03e8, 13'h07d0, 13'h0fa0})
    else $error("pulse length not a configured value");
  AST_PULSE_GAP: assert property (
    $fell(irq_pulse_out_n) |-> hi_cnt >= 7'h32)
    else $error("pulse retriggered before the high gap");
  AST_RD_PULSE: assert property (read_valid |=> !read_valid)
    else $error("read valid longer than one cycle");
  AST_STICKY: assert property (
    !read_valid |-> (event_flags & $past(event_flags)) == $past(event_flags))
    else $error("flag dropped without a read");
  AST_REQ_PULSE: assert property (
    $rose(event_flags[SIEP_SRC_REQ]) |-> ##[0:60] !irq_pulse_out_n)
    else $error("request gave no pulse");
  AST_IO_CHG: assert property (
    $changed(io_level) |-> ##[1:8] (event_flags[5:0] != 6'h00))
    else $error("io change not flagged");
  AST_IO_WAKE: assert property (
    (io_wake_event != 6'h00) |-> ##[1:3] (event_flags[11:6] != 6'h00))
    else $error("io wake not flagged");
  AST_BUS_WAKE: assert property (
    bus_wake_event |-> ##[1:3] event_flags[SIEP_SRC_BUS_WAKE])
    else $error("bus wake not flagged");
  AST_TXD_DOM: assert property (
    $rose(txd_clamp_dom) |-> ##[2:8] event_flags[SIEP_SRC_TXD_DOM])
    else $error("txd clamp not flagged");
  AST_TOPO: assert property (
    tcnt >= 3'h5 |-> pre_converter_topology_state == tprev)
    else $error("topology state not following input");
endmodule : siep_event_pulser_monitor

bind siep_event_pulser siep_event_pulser_monitor #(
  .NUM_IO(NUM_IO),
  .NUM_MON(NUM_MON)
) mon (.clock, .rst, .clk_en, .init_phase, .main_state, .sclk,
  .chip_select_n, .mosi, .io_level, .io_wake_event, .bus_wake_event,
  .txd_clamp_dom, .rxd_clamp_rec, .bus_stuck_dom, .sns_limit_timeout,
  .aux_limit_timeout, .pass_twarn, .monitor_fault,
  .pre_converter_topology_in, .irq_pulse_out_n,
  .pre_converter_topology_state, .event_flags, .read_data, .read_valid);

// >>> siep_host_model.sv
// host side spi master model
`timescale 1ns/1ps
module siep_host_model (
  input  wire logic clock,
  output logic      sclk,
  output logic      chip_select_n,
  output logic      mosi
);
  int half = 4;
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // msb first; n below 16 cuts the frame short on purpose
  task automatic xfer(input logic [15:0] f, input int n);
    @(posedge clock);
    chip_select_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      mosi <= f[i];
      tick(half);
      sclk <= 1'b1;
      tick(half);
      sclk <= 1'b0;
    end
    tick(half);
    chip_select_n <= 1'b1;
    // released data line must not keep showing the last bit
    mosi <= ~mosi;
    tick(8);
  endtask : xfer
endmodule : siep_host_model

// >>> siep_event_pulser_tb.sv
// self-checking bench for the interrupt event pulser
`timescale 1ns/1ps
module siep_event_pulser_tb;
  import siep_pkg::*;
  logic        clock, rst, clk_en, init_phase, main_state;
  logic [5:0]  io_level, io_wake_event, monitor_fault, msk, wk;
  logic        bus_wake_event, txd_clamp_dom, rxd_clamp_rec, bus_stuck_dom;
  logic        sns_limit_timeout, aux_limit_timeout, tp;
  logic        pre_converter_topology_in, pre_converter_topology_state;
  logic [2:0]  pass_twarn;
  logic [1:0]  len;
  logic        irq_pulse_out_n, read_valid;
  logic [31:0] event_flags;
  logic [7:0]  read_data, rd_q;
  wire logic   sclk, chip_select_n, mosi;
  logic [15:0] bad [7];
  logic [7:0]  bx [7];
  int          nb [7];
  int          err_count, checked, seed, n;

  siep_event_pulser uut (.clock, .rst, .clk_en, .init_phase, .main_state,
    .sclk, .chip_select_n, .mosi, .io_level, .io_wake_event,
    .bus_wake_event, .txd_clamp_dom, .rxd_clamp_rec, .bus_stuck_dom,
    .sns_limit_timeout, .aux_limit_timeout, .pass_twarn, .monitor_fault,
    .pre_converter_topology_in, .irq_pulse_out_n,
    .pre_converter_topology_state, .event_flags, .read_data, .read_valid);
  siep_host_model h (.clock, .sclk, .chip_select_n, .mosi);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (90000) @(posedge clock);
    err_count++;
    test_done();
  end
  always @(posedge clock) if (read_valid === 1'b1) rd_q <= read_data;

  function automatic logic [15:0] mk(input logic w, input logic [4:0] a,
                                     input logic [7:0] d);
    logic [15:0] f;
    f = {w, a, d, 2'b00};
    f[1] = ~^f[15:8];
    f[0] = ~^f[15:1];
    return f;
  endfunction : mk
  function automatic logic [15:0] plen(input logic [1:0] c);
    return {4'h0, SIEP_PULSE0_CYC} << c;
  endfunction : plen
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    rd_q = 8'hxx;
    h.xfer(mk(1'b0, a, 8'h00), 16);
    chk({8'h00, rd_q}, {8'h00, exp});
  endtask : rd
  task automatic pulse(output int n);
    int w;
    n = 0;
    w = 0;
    while (irq_pulse_out_n !== 1'b0 && w < 3000) begin
      @(posedge clock);
      w++;
    end
    while (irq_pulse_out_n === 1'b0 && n < 5000) begin
      @(posedge clock);
      n++;
    end
  endtask : pulse
  task automatic lows(input int span, output int n);
    n = 0;
    repeat (span) begin
      @(posedge clock);
      if (irq_pulse_out_n !== 1'b1) n++;
    end
  endtask : lows
  task automatic quiet;
    int c;
    c = 0;
    repeat (8000) begin
      @(posedge clock);
      if (c < 60) c = (irq_pulse_out_n === 1'b1) ? c + 1 : 0;
    end
  endtask : quiet
  task automatic test_done;
    if (err_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  initial begin
    seed = 99351;
    {err_count, checked, rst, clk_en, init_phase} = {32'h0, 32'h0, 3'b111};
    {main_state, io_level, io_wake_event, monitor_fault, pass_twarn} = '0;
    {bus_wake_event, txd_clamp_dom, rxd_clamp_rec, bus_stuck_dom} = 4'h0;
    {sns_limit_timeout, aux_limit_timeout, pre_converter_topology_in} = 3'h0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    len = 2'($random(seed));
    h.xfer(mk(1'b1, SIEP_ADDR_CFG, {6'h05, len}), 16);
    init_phase <= 1'b0;
    main_state <= 1'b1;
    fork
      begin
        h.xfer(mk(1'b1, SIEP_ADDR_REQ, 8'h01), 16);
        h.xfer(mk(1'b1, SIEP_ADDR_REQ, 8'h01), 16);
      end
      pulse(n);
    join
    chk(16'(n), plen(len));
    lows(200, n);
    chk(16'(n), 16'h0000);
    rd(SIEP_ADDR_FLAG0 + 5'h03, 8'h08);
    rd(SIEP_ADDR_FLAG0 + 5'h03, 8'h00);
    bad = '{mk(1'b0, 5'h0b, 8'h00) ^ 16'h0001, mk(1'b0, 5'h0b, 8'h00),
            mk(1'b0, 5'h0b, 8'h00) ^ 16'h0003, mk(1'b1, SIEP_ADDR_TOPO, 8'h00),
            mk(1'b0, 5'h1f, 8'h00), mk(1'b1, SIEP_ADDR_CFG, 8'h04),
            mk(1'b0, 5'h0b, 8'h01)};
    nb = '{16, 15, 16, 16, 16, 16, 16};
    bx = '{8'h80, 8'h20, 8'h10, 8'h40, 8'h40, 8'h40, 8'h40};
    h.half = 7;
    for (int k = 0; k < 7; k++) begin
      h.xfer(bad[k], nb[k]);
      rd(SIEP_ADDR_FLAG0 + 5'h03, bx[k]);
    end
    h.half = 4;
    quiet();
    h.xfer(mk(1'b1, SIEP_ADDR_MASK0, 8'h3f), 16);
    msk = 6'($random(seed)) | 6'h01;
    io_level <= msk;
    lows(300, n);
    chk(16'(n), 16'h0000);
    rd(SIEP_ADDR_FLAG0, {2'b00, msk});
    h.xfer(mk(1'b1, SIEP_ADDR_MASK0, 8'h00), 16);
    io_level <= msk ^ 6'h20;
    pulse(n);
    chk(16'(n), plen(len));
    rd(SIEP_ADDR_FLAG0, 8'h20);
    wk = 6'($random(seed)) | 6'h10;
    {io_wake_event, bus_wake_event, txd_clamp_dom} <= {wk, 2'b11};
    {rxd_clamp_rec, bus_stuck_dom, sns_limit_timeout} <= 3'b111;
    {aux_limit_timeout, pass_twarn, monitor_fault} <= 10'h3ff;
    @(posedge clock);
    {io_wake_event, bus_wake_event} <= 7'h00;
    repeat (10) @(posedge clock);
    rd(SIEP_ADDR_FLAG0, {wk[1:0], 6'h00});
    rd(SIEP_ADDR_FLAG0 + 5'h01, {4'hf, wk[5:2]});
    rd(SIEP_ADDR_FLAG0 + 5'h02, 8'hfd);
    rd(SIEP_ADDR_FLAG0 + 5'h03, 8'h07);
    tp = 1'($random(seed));
    for (int k = 0; k < 2; k++) begin
      pre_converter_topology_in <= tp;
      repeat (6) @(posedge clock);
      rd(SIEP_ADDR_TOPO, {7'h00, tp});
      tp = ~tp;
    end
    clk_en <= 1'b0;
    pre_converter_topology_in <= tp;
    repeat (10) @(posedge clock);
    chk({15'h0, pre_converter_topology_state}, {15'h0, ~tp});
    clk_en <= 1'b1;
    repeat (6) @(posedge clock);
    chk({15'h0, pre_converter_topology_state}, {15'h0, tp});
    rst <= 1'b1;
    {init_phase, main_state} <= 2'b10;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    h.xfer(mk(1'b1, SIEP_ADDR_CFG, 8'h00), 16);
    rd(SIEP_ADDR_FLAG0, 8'h00);
    io_level <= ~io_level;
    lows(300, n);
    chk(16'(n), 16'h0000);
    rd(SIEP_ADDR_FLAG0, 8'h3f);
    test_done();
  end
endmodule : siep_event_pulser_tb
